// ===== dv/fpe_flash_sequencer_assertions.sv
// port-level checker for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_sequencer_checker (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // register bus
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic [31:0] o_hrdata,
   // flash, source fetch, detector
   input wire logic o_fl_req,
   input wire logic [1:0] o_fl_cmd,
   input wire logic [31:0] o_fl_addr,
   input wire logic [31:0] o_fl_wdata,
   input wire logic i_fl_done,
   input wire logic o_src_req,
   input wire logic [31:0] o_src_addr,
   input wire logic i_src_ack,
   input wire logic [31:0] i_src_data,
   input wire logic o_lvd_enable
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);
   logic [31:0] src_q;
   // last fetched source word, so the row write can be tied to it
   always_ff @(posedge i_mclk) begin
      if (i_src_ack) begin
         src_q <= i_src_data;
      end
   end
   sequence taken(logic w, logic [7:0] a);
      i_hsel && i_hready && i_htrans[1] && i_hwrite == w && i_haddr == {24'h0, a};
   endsequence
   sequence ctl_write;
      taken(1'b1, fpe_pkg::OFS_OP_CONTROL) ##1 o_hreadyout;
   endsequence
   chk_key_read_zero: assert property (taken(1'b0, fpe_pkg::OFS_UNLOCK_KEY) |=> !o_hreadyout ##1 (o_hreadyout && o_hrdata == 32'h0))
      else $error("unlock key read returned nonzero");
   chk_enable_powers_lvd: assert property (ctl_write |=> o_lvd_enable == $past(i_hwdata[14]))
      else $error("detector enable does not follow the written enable bit");
   chk_reset_clears_enable: assert property (disable iff (1'b0) !i_nrst |=> !o_lvd_enable)
      else $error("device reset left the enable set");
   chk_flash_req_holds: assert property (o_fl_req && !i_fl_done |=> o_fl_req && $stable(o_fl_cmd) && $stable(o_fl_addr) && $stable(o_fl_wdata))
      else $error("flash command changed before done");
   chk_src_req_holds: assert property (o_src_req && !i_src_ack |=> o_src_req && $stable(o_src_addr))
      else $error("source fetch changed before ack");
   chk_row_data_used: assert property (o_src_req && i_src_ack |=> ##[0:3] (o_fl_req && o_fl_wdata == src_q))
      else $error("fetched word not written to flash");
   chk_word_aligned: assert property (o_fl_req && o_fl_cmd == fpe_pkg::FPE_CMD_WORD |-> o_fl_addr[1:0] == 2'b00)
      else $error("word address not aligned");
   chk_page_aligned: assert property (o_fl_req && o_fl_cmd == fpe_pkg::FPE_CMD_PAGE_ERASE |-> o_fl_addr[11:0] == 12'h000)
      else $error("page address not aligned");
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking testbench for the flash program/erase sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic [31:0] CTL = 32'h0;
   localparam logic [31:0] KEY = 32'h4;
   localparam logic [31:0] TGT = 32'h8;
   localparam logic [31:0] WRD = 32'hC;
   localparam logic [31:0] SRC = 32'h10;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_npor = 1'b0;
   logic i_hsel = 1'b1;
   logic [31:0] i_haddr = 32'h0;
   logic [1:0] i_htrans = 2'h0;
   logic i_hwrite = 1'b0;
   logic [31:0] i_hwdata = 32'h0;
   logic i_fl_done = 1'b0;
   logic i_fl_fail = 1'b0;
   logic i_tgt_protected = 1'b0;
   logic i_any_protected = 1'b0;
   logic i_src_ack = 1'b0;
   logic [31:0] i_src_data = 32'h0;
   logic i_low_volt = 1'b0;
   logic o_hreadyout, o_hresp, o_fl_req, o_src_req, o_lvd_enable;
   logic [1:0] o_fl_cmd, last_cmd;
   logic [1:0] wait_n = 2'h0;
   logic [31:0] o_hrdata, o_fl_addr, o_fl_wdata, o_src_addr, last_addr, last_wdata, rd;
   logic fail_mode = 1'b0;
   int fl_cnt = 0;
   int fails = 0;
   int checks = 0;
   // address, written value, value read back
   logic [31:0] rows [6][3] = '{'{TGT, 32'hDEAD_BEEF, 32'hDEAD_BEEF}, '{WRD, 32'h0BAD_F00D, 32'h0BAD_F00D},
      '{SRC, 32'h2000_0004, 32'h2000_0004}, '{KEY, 32'hFFFF_FFFF, 32'h0}, '{32'h14, 32'hFFFF_FFFF, 32'h0},
      '{CTL, 32'hFFFF_FF03, 32'h0000_4003}};
   logic [3:0] noops [5] = '{4'h0, 4'h2, 4'h6, 4'h7, 4'hF};
   fpe_flash_sequencer #(.ROW_WORDS(4)) i_fpe_flash_sequencer (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_npor(i_npor),
      .i_ce(1'b1), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'b010),
      .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
      .o_fl_req(o_fl_req), .o_fl_cmd(o_fl_cmd), .o_fl_addr(o_fl_addr), .o_fl_wdata(o_fl_wdata), .i_fl_done(i_fl_done),
      .i_fl_fail(i_fl_fail), .i_tgt_protected(i_tgt_protected), .i_any_protected(i_any_protected),
      .o_src_req(o_src_req), .o_src_addr(o_src_addr), .i_src_ack(i_src_ack), .i_src_data(i_src_data),
      .o_lvd_enable(o_lvd_enable), .i_low_volt(i_low_volt));
   initial begin
      forever #25 i_mclk = ~i_mclk;
   end
   // flash answers after three cycles so the request must be held meanwhile
   always @(posedge i_mclk) begin
      i_fl_done <= 1'b0;
      if (o_fl_req && !i_fl_done) begin
         wait_n <= wait_n + 2'h1;
         if (wait_n == 2'h2) begin
            wait_n <= 2'h0;
            i_fl_done <= 1'b1;
            i_fl_fail <= fail_mode;
            fl_cnt <= fl_cnt + 1;
            last_addr <= o_fl_addr;
            last_wdata <= o_fl_wdata;
            last_cmd <= o_fl_cmd;
         end
      end
   end
   // released source data is inverted so a stale capture shows up
   always @(posedge i_mclk) begin
      i_src_ack <= o_src_req && !i_src_ack;
      i_src_data <= (o_src_req && !i_src_ack) ? o_src_addr ^ 32'h5A5A_5A5A : ~i_src_data;
   end
   task automatic end_of_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      i_htrans <= 2'b10;
      i_haddr <= a;
      i_hwrite <= w;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'b00;
      i_hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      rd = o_hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic keys();
      wr(KEY, fpe_pkg::KEY_FIRST_DEFAULT);
      wr(KEY, fpe_pkg::KEY_SECOND_DEFAULT);
   endtask
   // two plain writes: the first drops enable, the second lands the code
   task automatic go(input logic [3:0] op);
      int n;
      wr(CTL, 32'(op));
      wr(CTL, 32'(op));
      wr(CTL, 32'h4000 | 32'(op));
      keys();
      wr(CTL, 32'hC000 | 32'(op));
      n = 0;
      do begin
         bus(1'b0, CTL, 32'h0);
         n++;
      end while (rd[15] !== 1'b0 && n < 300);
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      i_nrst <= 1'b1;
      i_npor <= 1'b1;
      @(posedge i_mclk);
      for (int r = 0; r < 6; r++) begin
         wr(rows[r][0], rows[r][1]);
         rchk(rows[r][0], rows[r][2]);
         check(32'(o_hresp), 32'h0000_0000);
      end
      wr(CTL, 32'h4005);
      rchk(CTL, 32'h4003);
      wr(CTL, 32'h0);
      keys();
      wr(CTL, 32'h8003);
      rchk(CTL, 32'h0003);
      wr(TGT, 32'h1006);
      go(fpe_pkg::OP_WORD_PROGRAM);
      check(rd, 32'h4001);
      check(last_addr, 32'h1004);
      check(last_wdata, 32'h0BAD_F00D);
      check(32'(fl_cnt), 32'h1);
      wr(TGT, 32'h1234);
      go(fpe_pkg::OP_ROW_PROGRAM);
      check(rd, 32'h4003);
      check(32'(fl_cnt), 32'h5);
      check(last_addr, 32'h120C);
      check(last_wdata, 32'h2000_0010 ^ 32'h5A5A_5A5A);
      wr(TGT, 32'h3456);
      go(fpe_pkg::OP_PAGE_ERASE);
      check(rd, 32'h4004);
      check(32'({last_cmd, last_addr[11:0]}), 32'h0000_1000);
      fail_mode <= 1'b1;
      go(fpe_pkg::OP_ARRAY_ERASE);
      fail_mode <= 1'b0;
      check(rd, 32'h6005);
      check(32'(last_cmd), 32'h2);
      foreach (noops[k]) begin
         go(noops[k]);
         check(rd, 32'h4000 | 32'(noops[k]));
      end
      i_any_protected <= 1'b1;
      go(fpe_pkg::OP_ARRAY_ERASE);
      check(rd, 32'h6005);
      i_any_protected <= 1'b0;
      go(fpe_pkg::OP_NONE);
      i_tgt_protected <= 1'b1;
      go(fpe_pkg::OP_WORD_PROGRAM);
      check(rd, 32'h6001);
      i_tgt_protected <= 1'b0;
      check(32'(fl_cnt), 32'h7);
      go(fpe_pkg::OP_NONE);
      i_low_volt <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rchk(CTL, 32'h5800);
      i_low_volt <= 1'b0;
      repeat (3) @(posedge i_mclk);
      rchk(CTL, 32'h5000);
      wr(CTL, 32'h0);
      i_low_volt <= 1'b1;
      repeat (3) @(posedge i_mclk);
      rchk(CTL, 32'h1000);
      i_low_volt <= 1'b0;
      go(fpe_pkg::OP_NONE);
      check(rd, 32'h4000);
      wr(CTL, 32'h0);
      wr(CTL, 32'h4001);
      keys();
      rchk(TGT, 32'h3456);
      wr(CTL, 32'hC001);
      rchk(CTL, 32'h4001);
      check(32'(fl_cnt), 32'h7);
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_nrst <= 1'b1;
      @(posedge i_mclk);
      rchk(CTL, 32'h0001);
      rchk(WRD, 32'h0BAD_F00D);
      i_nrst <= 1'b0;
      i_npor <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_nrst <= 1'b1;
      i_npor <= 1'b1;
      @(posedge i_mclk);
      rchk(WRD, 32'h0);
      end_of_test();
   end
   // the whole sequence needs a few hundred cycles; this allows forty thousand
   initial begin
      #2000000;
      fails++;
      end_of_test();
   end
endmodule
bind fpe_flash_sequencer fpe_flash_sequencer_checker i_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_fl_req(o_fl_req), .o_fl_cmd(o_fl_cmd), .o_fl_addr(o_fl_addr),
   .o_fl_wdata(o_fl_wdata), .i_fl_done(i_fl_done), .o_src_req(o_src_req), .o_src_addr(o_src_addr),
   .i_src_ack(i_src_ack), .i_src_data(i_src_data), .o_lvd_enable(o_lvd_enable));
`default_nettype wire

// ===== logic/fpe_flash_sequencer.sv
// flash program/erase sequencer with AHB-Lite register slave
//
// How it works
// - start bit takes a one only when enabled and just unlocked
// - start launches the operation; hardware clears it at completion
// - enable permits start writes and powers the low-voltage detector
// - device reset clears only the enable bit of the control register
// - failed program or erase sets the read-only fail flag
// - low supply with detector on sets the low-voltage error flag
// - low-voltage status follows the detector while it is enabled
// - start with operation none clears the fail and low-voltage error flags
// - operation select is writable only while enable is zero
// - code 0101 erases the whole array unless any page is protected
// - code 0100 erases the addressed page unless it is protected
// - code 0011 programs the addressed row unless it is protected
// - code 0001 programs a word; 0000, 0010, 0110 and reserved do nothing
// - unlock key register is write-only and reads as zero
// - target address is ignored, page, row or word by operation
// - program word register is cleared by power-on reset only
// - row programming fetches its data from the source address
// - a page is 4 KB, a row is 512 bytes
`timescale 1ns/100ps
`default_nettype none
module fpe_flash_sequencer #(
   parameter int ROW_WORDS = fpe_pkg::ROW_WORDS,
   parameter logic [31:0] KEY_FIRST = fpe_pkg::KEY_FIRST_DEFAULT,
   parameter logic [31:0] KEY_SECOND = fpe_pkg::KEY_SECOND_DEFAULT
) (
   // clock, resets, enable
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_npor,
   input wire logic i_ce,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // flash array command port
   output logic o_fl_req,
   output logic [1:0] o_fl_cmd,
   output logic [31:0] o_fl_addr,
   output logic [31:0] o_fl_wdata,
   input wire logic i_fl_done,
   input wire logic i_fl_fail,
   // write protection of the addressed region / of any page
   input wire logic i_tgt_protected,
   input wire logic i_any_protected,
   // row source fetch port
   output logic o_src_req,
   output logic [31:0] o_src_addr,
   input wire logic i_src_ack,
   input wire logic [31:0] i_src_data,
   // low-voltage detector
   output logic o_lvd_enable,
   input wire logic i_low_volt
);
   typedef enum logic [2:0] {
      FPE_IDLE,
      FPE_FLASH,
      FPE_FETCH,
      FPE_ROW_WRITE,
      FPE_FINISH
   } fpe_state_e;

   localparam logic [31:0] PAGE_MASK = ~(32'(fpe_pkg::PAGE_BYTES) - 32'h0000_0001);
   localparam logic [31:0] ROW_MASK = ~(32'(fpe_pkg::ROW_BYTES) - 32'h0000_0001);
   localparam logic [31:0] WORD_MASK = ~(32'(fpe_pkg::WORD_BYTES) - 32'h0000_0001);
   localparam int CNT_W = $clog2(ROW_WORDS);
   localparam logic [1:0] FPE_CMD_WORD_CODE = 2'(fpe_pkg::FPE_CMD_WORD);
   localparam logic [1:0] FPE_CMD_PAGE_CODE = 2'(fpe_pkg::FPE_CMD_PAGE_ERASE);
   localparam logic [1:0] FPE_CMD_ARRAY_CODE = 2'(fpe_pkg::FPE_CMD_ARRAY_ERASE);

   // control register state
   logic program_enable;
   logic start;
   logic op_fail_flag;
   logic low_volt_error;
   logic low_volt_active;
   logic [3:0] op_select;
   // data registers
   logic [31:0] flash_target_address;
   logic [31:0] flash_program_word;
   logic [31:0] row_source_address;
   // bus data phase
   logic ph_valid;
   logic ph_write;
   logic [7:0] ph_addr;
   logic rd_done;
   logic rd_pend;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_key;
   logic unlocked;
   logic start_ok;
   logic clear_evt;
   // sequencer
   fpe_state_e state;
   logic [CNT_W-1:0] word_cnt;
   logic op_failed;
   logic finish_evt;
   logic [31:0] read_mux;

   // ---------------- bus slave ----------------
   // reads take one wait state so read data always come from a flop
   assign rd_pend = ph_valid && !ph_write && !rd_done;
   assign o_hreadyout = !rd_pend;
   assign o_hresp = 1'b0;
   assign wr_fire = ph_valid && ph_write;
   assign wr_ctrl = wr_fire && (ph_addr == fpe_pkg::OFS_OP_CONTROL);
   assign wr_key = wr_fire && (ph_addr == fpe_pkg::OFS_UNLOCK_KEY);

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr <= 8'h00;
         rd_done <= 1'b0;
      end else if (i_ce) begin
         if (i_hready) begin
            ph_valid <= i_hsel && i_htrans[1];
            ph_write <= i_hwrite;
            ph_addr <= i_haddr[7:0];
            rd_done <= 1'b0;
         end else if (rd_pend) begin
            rd_done <= 1'b1;
         end
      end
   end

   always_comb begin
      read_mux = 32'h0000_0000;
      if (ph_addr == fpe_pkg::OFS_OP_CONTROL) begin
         read_mux[fpe_pkg::BIT_START] = start;
         read_mux[fpe_pkg::BIT_PROGRAM_ENABLE] = program_enable;
         read_mux[fpe_pkg::BIT_OP_FAIL] = op_fail_flag;
         read_mux[fpe_pkg::BIT_LOW_VOLT_ERROR] = low_volt_error;
         read_mux[fpe_pkg::BIT_LOW_VOLT_ACTIVE] = low_volt_active;
         read_mux[fpe_pkg::OP_SELECT_LSB +: fpe_pkg::OP_SELECT_W] = op_select;
      end else if (ph_addr == fpe_pkg::OFS_UNLOCK_KEY) begin
         read_mux = 32'h0000_0000;
      end else if (ph_addr == fpe_pkg::OFS_TARGET_ADDR) begin
         read_mux = flash_target_address;
      end else if (ph_addr == fpe_pkg::OFS_PROGRAM_WORD) begin
         read_mux = flash_program_word;
      end else if (ph_addr == fpe_pkg::OFS_ROW_SOURCE) begin
         read_mux = row_source_address;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_hrdata <= fpe_pkg::RESET_WORD;
      end else if (i_ce && rd_pend) begin
         o_hrdata <= read_mux;
      end
   end

   // ---------------- unlock ----------------
   fpe_unlock #(
      .KEY_FIRST(KEY_FIRST),
      .KEY_SECOND(KEY_SECOND)
   ) u_unlock (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_key_wr(wr_key),
      .i_key_data(i_hwdata),
      .i_other_access(rd_pend || (wr_fire && !wr_key)),
      .o_unlocked(unlocked)
   );

   // start only with enable set, fresh unlock, and nothing running
   assign start_ok = wr_ctrl && i_hwdata[fpe_pkg::BIT_START] && program_enable && unlocked && !start;
   assign clear_evt = start_ok && (op_select == fpe_pkg::OP_NONE);

   // ---------------- control register ----------------
   // device reset touches the enable bit alone; the rest wait for power-on
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || !i_npor) begin
         program_enable <= 1'b0;
      end else if (i_ce && wr_ctrl) begin
         program_enable <= i_hwdata[fpe_pkg::BIT_PROGRAM_ENABLE];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         op_select <= fpe_pkg::RESET_OP;
      end else if (i_ce && wr_ctrl && !program_enable) begin
         op_select <= i_hwdata[fpe_pkg::OP_SELECT_LSB +: fpe_pkg::OP_SELECT_W];
      end
   end

   // start stays high through the run and drops at completion
   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         start <= 1'b0;
      end else if (i_ce) begin
         if (start_ok) begin
            start <= 1'b1;
         end else if (finish_evt) begin
            start <= 1'b0;
         end
      end
   end

   // detector only powered while programming is enabled
   assign o_lvd_enable = program_enable;

   // status follows the detector; a clear cannot hide a live event
   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         low_volt_active <= 1'b0;
      end else if (i_ce) begin
         low_volt_active <= program_enable && i_low_volt;
      end
   end

   // sticky flags: a set in the clearing cycle wins
   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         low_volt_error <= 1'b0;
      end else if (i_ce) begin
         if (program_enable && i_low_volt) begin
            low_volt_error <= 1'b1;
         end else if (clear_evt) begin
            low_volt_error <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         op_fail_flag <= 1'b0;
      end else if (i_ce) begin
         if (finish_evt && op_failed) begin
            op_fail_flag <= 1'b1;
         end else if (clear_evt) begin
            op_fail_flag <= 1'b0;
         end
      end
   end

   // ---------------- data registers ----------------
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         flash_target_address <= fpe_pkg::RESET_WORD;
         row_source_address <= fpe_pkg::RESET_WORD;
      end else if (i_ce && wr_fire) begin
         if (ph_addr == fpe_pkg::OFS_TARGET_ADDR) begin
            flash_target_address <= i_hwdata;
         end else if (ph_addr == fpe_pkg::OFS_ROW_SOURCE) begin
            row_source_address <= i_hwdata;
         end
      end
   end

   // survives every reset except power-on
   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         flash_program_word <= fpe_pkg::RESET_WORD;
      end else if (i_ce && wr_fire && ph_addr == fpe_pkg::OFS_PROGRAM_WORD) begin
         flash_program_word <= i_hwdata;
      end
   end

   // ---------------- sequencer ----------------
   // a device reset does not stop a running operation; half-written flash is worse
   assign finish_evt = (state == FPE_FINISH);
   assign o_fl_req = (state == FPE_FLASH) || (state == FPE_ROW_WRITE);
   assign o_src_req = (state == FPE_FETCH);

   always_ff @(posedge i_mclk) begin
      if (!i_npor) begin
         state <= FPE_IDLE;
         word_cnt <= '0;
         op_failed <= 1'b0;
         o_fl_cmd <= FPE_CMD_WORD_CODE;
         o_fl_addr <= fpe_pkg::RESET_WORD;
         o_fl_wdata <= fpe_pkg::RESET_WORD;
         o_src_addr <= fpe_pkg::RESET_WORD;
      end else if (i_ce) begin
         case (state)
            FPE_IDLE: begin
               word_cnt <= '0;
               if (start_ok) begin
                  op_failed <= 1'b0;
                  state <= FPE_FINISH;
                  if (op_select == fpe_pkg::OP_ARRAY_ERASE) begin
                     // address ignored for the whole array
                     o_fl_cmd <= FPE_CMD_ARRAY_CODE;
                     o_fl_addr <= fpe_pkg::RESET_WORD;
                     op_failed <= i_any_protected;
                     state <= i_any_protected ? FPE_FINISH : FPE_FLASH;
                  end else if (op_select == fpe_pkg::OP_PAGE_ERASE) begin
                     o_fl_cmd <= FPE_CMD_PAGE_CODE;
                     o_fl_addr <= flash_target_address & PAGE_MASK;
                     op_failed <= i_tgt_protected;
                     state <= i_tgt_protected ? FPE_FINISH : FPE_FLASH;
                  end else if (op_select == fpe_pkg::OP_ROW_PROGRAM) begin
                     o_fl_cmd <= FPE_CMD_WORD_CODE;
                     o_fl_addr <= flash_target_address & ROW_MASK;
                     o_src_addr <= row_source_address & WORD_MASK;
                     op_failed <= i_tgt_protected;
                     state <= i_tgt_protected ? FPE_FINISH : FPE_FETCH;
                  end else if (op_select == fpe_pkg::OP_WORD_PROGRAM) begin
                     o_fl_cmd <= FPE_CMD_WORD_CODE;
                     o_fl_addr <= flash_target_address & WORD_MASK;
                     o_fl_wdata <= flash_program_word;
                     op_failed <= i_tgt_protected;
                     state <= i_tgt_protected ? FPE_FINISH : FPE_FLASH;
                  end
                  // other codes fall through to finish as no operation
               end
            end
            FPE_FLASH: begin
               if (i_fl_done) begin
                  op_failed <= i_fl_fail || low_volt_active;
                  state <= FPE_FINISH;
               end
            end
            FPE_FETCH: begin
               if (i_src_ack) begin
                  o_fl_wdata <= i_src_data;
                  state <= FPE_ROW_WRITE;
               end
            end
            FPE_ROW_WRITE: begin
               if (i_fl_done) begin
                  if (i_fl_fail || low_volt_active) begin
                     op_failed <= 1'b1;
                     state <= FPE_FINISH;
                  end else if (word_cnt == CNT_W'(ROW_WORDS - 1)) begin
                     state <= FPE_FINISH;
                  end else begin
                     word_cnt <= word_cnt + 1'b1;
                     o_fl_addr <= o_fl_addr + 32'(fpe_pkg::WORD_BYTES);
                     o_src_addr <= o_src_addr + 32'(fpe_pkg::WORD_BYTES);
                     state <= FPE_FETCH;
                  end
               end
            end
            default: begin
               state <= FPE_IDLE;
            end
         endcase
      end
   end

   // bus size is not checked; only whole-word transfers are expected
   logic unused_ok;
   assign unused_ok = ^{i_hsize, i_htrans[0], i_haddr[31:8]};
endmodule
`default_nettype wire

// ===== logic/fpe_pkg.sv
// constants shared by the flash program/erase sequencer
package fpe_pkg;
   // register byte offsets on the system bus
   localparam logic [7:0] OFS_OP_CONTROL = 8'h00;
   localparam logic [7:0] OFS_UNLOCK_KEY = 8'h04;
   localparam logic [7:0] OFS_TARGET_ADDR = 8'h08;
   localparam logic [7:0] OFS_PROGRAM_WORD = 8'h0C;
   localparam logic [7:0] OFS_ROW_SOURCE = 8'h10;
   // flash_op_control field positions
   localparam int BIT_START = 15;
   localparam int BIT_PROGRAM_ENABLE = 14;
   localparam int BIT_OP_FAIL = 13;
   localparam int BIT_LOW_VOLT_ERROR = 12;
   localparam int BIT_LOW_VOLT_ACTIVE = 11;
   localparam int OP_SELECT_LSB = 0;
   localparam int OP_SELECT_W = 4;
   // reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [3:0] RESET_OP = 4'h0;
   // operation codes
   localparam logic [3:0] OP_NONE = 4'h0;
   localparam logic [3:0] OP_WORD_PROGRAM = 4'h1;
   localparam logic [3:0] OP_NONE_2 = 4'h2;
   localparam logic [3:0] OP_ROW_PROGRAM = 4'h3;
   localparam logic [3:0] OP_PAGE_ERASE = 4'h4;
   localparam logic [3:0] OP_ARRAY_ERASE = 4'h5;
   localparam logic [3:0] OP_NONE_6 = 4'h6;
   // geometry in bytes
   localparam int PAGE_BYTES = 4096;
   localparam int ROW_BYTES = 512;
   localparam int WORD_BYTES = 4;
   localparam int ROW_WORDS = ROW_BYTES / WORD_BYTES;
   // unlock keys; values are arbitrary
   localparam logic [31:0] KEY_FIRST_DEFAULT = 32'h1234_5678;
   localparam logic [31:0] KEY_SECOND_DEFAULT = 32'h8765_4321;
   // commands to the flash array
   typedef enum logic [1:0] {
      FPE_CMD_WORD,
      FPE_CMD_PAGE_ERASE,
      FPE_CMD_ARRAY_ERASE
   } fpe_cmd_e;
endpackage

// ===== logic/fpe_unlock.sv
// unlock sequence tracker: two key writes back to back arm one start
`timescale 1ns/100ps
`default_nettype none
module fpe_unlock #(
   parameter logic [31:0] KEY_FIRST = fpe_pkg::KEY_FIRST_DEFAULT,
   parameter logic [31:0] KEY_SECOND = fpe_pkg::KEY_SECOND_DEFAULT
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // bus activity
   input wire logic i_key_wr,
   input wire logic [31:0] i_key_data,
   input wire logic i_other_access,
   // state
   output logic o_unlocked
);
   typedef enum logic [1:0] {
      FPE_LOCKED,
      FPE_HALF,
      FPE_OPEN
   } fpe_lock_e;
   fpe_lock_e lock_state;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         lock_state <= FPE_LOCKED;
      end else if (i_ce) begin
         if (i_other_access) begin
            // any other access, or the start write itself, re-locks
            lock_state <= FPE_LOCKED;
         end else if (i_key_wr) begin
            case (lock_state)
               FPE_LOCKED: lock_state <= (i_key_data == KEY_FIRST) ? FPE_HALF : FPE_LOCKED;
               FPE_HALF: lock_state <= (i_key_data == KEY_SECOND) ? FPE_OPEN :
                  ((i_key_data == KEY_FIRST) ? FPE_HALF : FPE_LOCKED);
               default: lock_state <= (i_key_data == KEY_FIRST) ? FPE_HALF : FPE_LOCKED;
            endcase
         end
      end
   end

   assign o_unlocked = (lock_state == FPE_OPEN);
endmodule
`default_nettype wire
